// ### design/ccb_pkg.sv
// constants, field layout and types shared by the clock and time base control block
package ccb_pkg;

	// counter widths and presets
	localparam int CCB_TB_W = 14;
	localparam int CCB_DIV_W = 7;
	localparam int CCB_STAB_W = 6;
	localparam logic [13:0] CCB_TB_PRESET = 14'h0078;
	localparam logic [6:0] CCB_DIV_PRESET = 7'h78;
	localparam logic [5:0] CCB_STAB_PRESET = 6'h00;

	// register offsets
	localparam logic [7:0] CCB_ADDR_CLK_CTRL = 8'h2E;
	localparam logic [7:0] CCB_ADDR_TB_CTRL1 = 8'h10;
	localparam logic [7:0] CCB_ADDR_TB_CTRL2 = 8'h11;

	// clock_control_register fields
	localparam int CCB_CC_MAIN_RDY_BIT = 7;
	localparam int CCB_CC_SUB_RDY_BIT = 6;
	localparam int CCB_CC_SYS_SEL_LSB = 2;
	localparam int CCB_CC_MAIN_EN_BIT = 1;
	localparam int CCB_CC_MAP_BIT = 0;

	// time_base_control_one and time_base_control_two fields
	localparam int CCB_TB1_SRC_BIT = 1;
	localparam int CCB_TB1_LCD_RATE_BIT = 0;
	localparam int CCB_TB2_FLAG_BIT = 7;
	localparam int CCB_TB2_IE_BIT = 6;
	localparam int CCB_TB2_RATE_LSB = 0;

	// reset values
	localparam logic [1:0] CCB_SYS_SEL_RST = 2'h0;
	localparam logic CCB_MAIN_EN_RST = 1'h0;
	localparam logic CCB_MAP_RST = 1'h0;
	localparam logic CCB_TB_SRC_RST = 1'h0;
	localparam logic CCB_LCD_RATE_RST = 1'h0;
	localparam logic [1:0] CCB_TICK_RATE_RST = 2'h0;
	localparam logic CCB_TICK_IE_RST = 1'h0;

	// system clock select encodings and divider taps
	localparam logic [1:0] CCB_SYS_MAIN_DIV2 = 2'h0;
	localparam logic [1:0] CCB_SYS_MAIN_DIV4 = 2'h1;
	localparam logic [1:0] CCB_SYS_MAIN_DIV64 = 2'h2;
	localparam logic [1:0] CCB_SYS_SUB_DIV2 = 2'h3;
	localparam int CCB_BUS_TAP_DIV2 = 0;
	localparam int CCB_BUS_TAP_DIV4 = 1;
	localparam int CCB_BUS_TAP_DIV64 = 5;

	// lcd frame taps on the time base: bit 5 halves every 64 counts, bit 6 every 128
	localparam int CCB_LCD_TAP_FAST = 5;
	localparam int CCB_LCD_TAP_SLOW = 6;

	typedef enum logic [2:0] {
		CCB_RUN = 3'b001,
		CCB_WAIT = 3'b010,
		CCB_STOP = 3'b100
	} ccb_mode_e;

	// low-bit mask whose all-ones state ends one tick period: 128, 4096, 8192, 16384
	function automatic logic [13:0] ccb_tick_mask(input logic [1:0] rate);
		case (rate)
			2'h0: ccb_tick_mask = 14'h007F;
			2'h1: ccb_tick_mask = 14'h0FFF;
			2'h2: ccb_tick_mask = 14'h1FFF;
			default: ccb_tick_mask = 14'h3FFF;
		endcase
	endfunction : ccb_tick_mask

endpackage : ccb_pkg

// ### design/ccb_counter.sv
// presettable up-counter with wrap pulse, used for the time base and main dividers
`timescale 1ns/1ps
module ccb_counter
	import ccb_pkg::*;
#(
	parameter int W = 14,
	parameter logic [W-1:0] PRESET = '0
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// control
	input wire logic preset_i,
	input wire logic inc_i,
	// state
	output logic [W-1:0] count_o,
	output logic wrap_o
);

	assign wrap_o = inc_i && !preset_i && (count_o == {W{1'b1}});

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			count_o <= PRESET;
		else if (ce_i)
		begin
			if (preset_i)
				count_o <= PRESET;
			else if (inc_i)
				count_o <= count_o + 1'b1;
		end
	end

endmodule : ccb_counter

// ### design/ccb_power_mode.sv
// run, wait and stop sequencing of the cpu and peripheral clocks
`timescale 1ns/1ps
module ccb_power_mode
	import ccb_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// requests and wake sources
	input wire logic rst_any_i,
	input wire logic stop_req_i,
	input wire logic wait_req_i,
	input wire logic stop_wake_i,
	input wire logic irq_any_i,
	// state
	output ccb_mode_e mode_o,
	output logic cpu_run_o,
	output logic periph_run_o
);

	ccb_mode_e next_mode;

	always_comb
	begin
		next_mode = mode_o;
		case (mode_o)
			CCB_RUN:
				if (rst_any_i)
					next_mode = CCB_RUN;
				else if (stop_req_i)
					next_mode = CCB_STOP;
				else if (wait_req_i)
					next_mode = CCB_WAIT;
			CCB_WAIT:
				if (rst_any_i || irq_any_i || stop_wake_i)
					next_mode = CCB_RUN;
			CCB_STOP:
				// the sub crystal never stops, so the cpu restarts at once
				if (rst_any_i || stop_wake_i)
					next_mode = CCB_RUN;
			default:
				next_mode = CCB_RUN;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mode_o <= CCB_RUN;
			cpu_run_o <= 1'b1;
			periph_run_o <= 1'b1;
		end
		else if (ce_i)
		begin
			mode_o <= next_mode;
			cpu_run_o <= (next_mode == CCB_RUN);
			periph_run_o <= (next_mode != CCB_STOP);
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_stop_woken;
		mode_o == CCB_STOP && ce_i && (rst_any_i || stop_wake_i);
	endsequence

	sequence s_wait_woken;
		mode_o == CCB_WAIT && ce_i && (rst_any_i || irq_any_i || stop_wake_i);
	endsequence

	a_stop_exit_now: assert property (s_stop_woken |=> mode_o == CCB_RUN && cpu_run_o && periph_run_o)
		else $error("stop not left in one cycle");
	a_wait_exit_now: assert property (s_wait_woken |=> mode_o == CCB_RUN && cpu_run_o)
		else $error("wait not left on reset or interrupt");
	a_stop_halts_all: assert property (mode_o == CCB_STOP |-> !cpu_run_o && !periph_run_o)
		else $error("clocks running in stop");
	a_wait_keeps_periph: assert property (mode_o == CCB_WAIT |-> !cpu_run_o && periph_run_o)
		else $error("wait gates the wrong clocks");

endmodule : ccb_power_mode

// ### design/ccb_clock_ctrl.sv
// clock and time base control: dividers, ready flags, bus clock, lcd and tick taps, registers
`timescale 1ns/1ps
module ccb_clock_ctrl
	import ccb_pkg::*;
(
	// clock, power-on reset and clock enable
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// crystal clocks, sampled as levels
	input wire logic sub_crystal_clock_i,
	input wire logic main_crystal_clock_i,
	// ordinary resets
	input wire logic ext_reset_i,
	input wire logic watchdog_reset_i,
	// cpu mode requests and wake sources
	input wire logic stop_req_i,
	input wire logic wait_req_i,
	input wire logic ext_irq_i,
	input wire logic spi_slave_event_i,
	input wire logic irq_any_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// clocks and enables to the core
	output logic bus_clock_phase_o,
	output logic cpu_run_o,
	output logic periph_run_o,
	output logic core_reset_o,
	output logic main_crystal_run_o,
	output logic alternate_map_select_o,
	// time base taps
	output logic lcd_frame_clock_o,
	output logic tick_interrupt_o,
	output logic watchdog_tap_o
);

	// control bits
	logic [1:0] system_clock_select;
	logic main_crystal_enable;
	logic time_base_source_select;
	logic lcd_rate_select;
	logic [1:0] tick_rate_select;
	logic tick_irq_enable;

	// status
	logic sub_clock_ready_flag;
	logic main_clock_ready_flag;
	logic tick_flag;

	// edge detection and counters
	logic sub_q;
	logic main_q;
	logic sub_edge;
	logic main_edge;
	logic sub_half;
	logic main_on;
	logic [CCB_DIV_W-1:0] main_div;
	logic div_wrap;
	logic [CCB_STAB_W-1:0] main_stab;
	logic stab_wrap;
	logic [CCB_TB_W-1:0] tb_cnt;
	logic tb_inc;
	logic tb_wrap;
	logic tick_pulse;
	logic rst_ord;
	logic tick_clr;
	logic next_bus;
	ccb_mode_e mode;

	assign sub_edge = sub_crystal_clock_i && !sub_q;
	assign main_edge = main_crystal_clock_i && !main_q;
	// ordinary resets, plus the hold while the power-up divider has not yet run out
	assign rst_ord = ext_reset_i || watchdog_reset_i || !sub_clock_ready_flag;
	assign main_on = main_crystal_enable && (mode != CCB_STOP);
	// the main divider feeds the time base at main/128; stopping main stalls it
	assign tb_inc = time_base_source_select ? div_wrap : sub_edge;
	assign tick_pulse = tb_inc && ((tb_cnt & ccb_tick_mask(tick_rate_select)) ==
		ccb_tick_mask(tick_rate_select));
	assign tick_clr = reg_wr_i && (reg_addr_i == CCB_ADDR_TB_CTRL2) && reg_wdata_i[CCB_TB2_FLAG_BIT];

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sub_q <= 1'b0;
			main_q <= 1'b0;
			sub_half <= 1'b0;
		end
		else if (ce_i)
		begin
			sub_q <= sub_crystal_clock_i;
			main_q <= main_crystal_clock_i;
			if (sub_edge)
				sub_half <= !sub_half;
		end
	end

	// main divider and stabilisation counter, held at preset while main is disabled
	ccb_counter #(.W(CCB_DIV_W), .PRESET(CCB_DIV_PRESET)) u_main_div (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.preset_i(!main_crystal_enable),
		.inc_i(main_on && main_edge),
		.count_o(main_div),
		.wrap_o(div_wrap)
	);

	ccb_counter #(.W(CCB_STAB_W), .PRESET(CCB_STAB_PRESET)) u_main_stab (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.preset_i(!main_crystal_enable),
		.inc_i(div_wrap),
		.count_o(main_stab),
		.wrap_o(stab_wrap)
	);

	// time base only sees the power-on reset; ordinary resets leave it running
	ccb_counter #(.W(CCB_TB_W), .PRESET(CCB_TB_PRESET)) u_time_base (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.preset_i(1'b0),
		.inc_i(tb_inc),
		.count_o(tb_cnt),
		.wrap_o(tb_wrap)
	);

	ccb_power_mode u_mode (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.rst_any_i(ext_reset_i || watchdog_reset_i),
		.stop_req_i(stop_req_i && sub_clock_ready_flag),
		.wait_req_i(wait_req_i && sub_clock_ready_flag),
		.stop_wake_i(ext_irq_i || spi_slave_event_i || tick_interrupt_o),
		.irq_any_i(irq_any_i),
		.mode_o(mode),
		.cpu_run_o(cpu_run_o),
		.periph_run_o(periph_run_o)
	);

	// ready flags: only power-on clears the sub flag
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sub_clock_ready_flag <= 1'b0;
			core_reset_o <= 1'b1;
		end
		else if (ce_i)
		begin
			if (tb_wrap)
				sub_clock_ready_flag <= 1'b1;
			// external and watchdog resets pass straight through with no start-up wait
			core_reset_o <= !(sub_clock_ready_flag || tb_wrap) || ext_reset_i || watchdog_reset_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			main_clock_ready_flag <= 1'b0;
		else if (ce_i)
		begin
			if (!main_crystal_enable)
				main_clock_ready_flag <= 1'b0;
			else if (stab_wrap)
				main_clock_ready_flag <= 1'b1;
		end
	end

	// control registers, returned to reset values by any ordinary reset
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			system_clock_select <= CCB_SYS_SEL_RST;
			main_crystal_enable <= CCB_MAIN_EN_RST;
			alternate_map_select_o <= CCB_MAP_RST;
			time_base_source_select <= CCB_TB_SRC_RST;
			lcd_rate_select <= CCB_LCD_RATE_RST;
			tick_rate_select <= CCB_TICK_RATE_RST;
			tick_irq_enable <= CCB_TICK_IE_RST;
		end
		else if (ce_i)
		begin
			if (rst_ord)
			begin
				system_clock_select <= CCB_SYS_SEL_RST;
				main_crystal_enable <= CCB_MAIN_EN_RST;
				alternate_map_select_o <= CCB_MAP_RST;
				time_base_source_select <= CCB_TB_SRC_RST;
				lcd_rate_select <= CCB_LCD_RATE_RST;
				tick_rate_select <= CCB_TICK_RATE_RST;
				tick_irq_enable <= CCB_TICK_IE_RST;
			end
			else if (reg_wr_i)
			begin
				case (reg_addr_i)
					CCB_ADDR_CLK_CTRL:
					begin
						system_clock_select <= reg_wdata_i[CCB_CC_SYS_SEL_LSB +: 2];
						main_crystal_enable <= reg_wdata_i[CCB_CC_MAIN_EN_BIT];
						alternate_map_select_o <= reg_wdata_i[CCB_CC_MAP_BIT];
					end
					CCB_ADDR_TB_CTRL1:
					begin
						time_base_source_select <= reg_wdata_i[CCB_TB1_SRC_BIT];
						lcd_rate_select <= reg_wdata_i[CCB_TB1_LCD_RATE_BIT];
					end
					CCB_ADDR_TB_CTRL2:
					begin
						tick_irq_enable <= reg_wdata_i[CCB_TB2_IE_BIT];
						tick_rate_select <= reg_wdata_i[CCB_TB2_RATE_LSB +: 2];
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	// tick flag: a tick in the same cycle as a write-one clear wins
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			tick_flag <= 1'b0;
		else if (ce_i)
		begin
			if (tick_pulse)
				tick_flag <= 1'b1;
			else if (tick_clr || rst_ord)
				tick_flag <= 1'b0;
		end
	end

	// time base outputs
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			lcd_frame_clock_o <= 1'b0;
			tick_interrupt_o <= 1'b0;
			watchdog_tap_o <= 1'b0;
		end
		else if (ce_i)
		begin
			lcd_frame_clock_o <= lcd_rate_select ? tb_cnt[CCB_LCD_TAP_SLOW] : tb_cnt[CCB_LCD_TAP_FAST];
			tick_interrupt_o <= tick_flag && tick_irq_enable;
			watchdog_tap_o <= tick_pulse;
		end
	end

	// bus clock: frozen in stop, since every module but the time base halts
	always_comb
	begin
		case (system_clock_select)
			CCB_SYS_MAIN_DIV2: next_bus = main_div[CCB_BUS_TAP_DIV2];
			CCB_SYS_MAIN_DIV4: next_bus = main_div[CCB_BUS_TAP_DIV4];
			CCB_SYS_MAIN_DIV64: next_bus = main_div[CCB_BUS_TAP_DIV64];
			default: next_bus = sub_half;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bus_clock_phase_o <= 1'b0;
			main_crystal_run_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (mode != CCB_STOP)
				bus_clock_phase_o <= next_bus;
			main_crystal_run_o <= main_on;
		end
	end

	// read data stands one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			reg_rdata_o <= 8'h00;
		else if (ce_i)
		begin
			reg_rdata_o <= 8'h00;
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					CCB_ADDR_CLK_CTRL:
						reg_rdata_o <= {main_clock_ready_flag, sub_clock_ready_flag, 2'b00,
							system_clock_select, main_crystal_enable, alternate_map_select_o};
					CCB_ADDR_TB_CTRL1:
						reg_rdata_o <= {6'h00, time_base_source_select, lcd_rate_select};
					CCB_ADDR_TB_CTRL2:
						reg_rdata_o <= {tick_flag, tick_irq_enable, 4'h0, tick_rate_select};
					default:
						reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_tb_step;
		ce_i && tb_inc && !tb_wrap;
	endsequence

	a_tb_counts_up: assert property (s_tb_step |=> tb_cnt == CCB_TB_W'($past(tb_cnt) + 14'h0001))
		else $error("time base did not step by one");
	a_sub_ready_set: assert property (ce_i && tb_wrap |=> sub_clock_ready_flag)
		else $error("sub ready flag missed the overflow");
	a_sub_ready_sticky: assert property (sub_clock_ready_flag |=> sub_clock_ready_flag)
		else $error("sub ready flag dropped");
	a_por_release: assert property (ce_i && tb_wrap && !ext_reset_i && !watchdog_reset_i |=> !core_reset_o)
		else $error("power-on reset not released");
	a_ext_reset_fast: assert property (ce_i && ext_reset_i |=> core_reset_o)
		else $error("external reset delayed");
	a_lcd_tap_sel: assert property (ce_i |=> lcd_frame_clock_o ==
		($past(lcd_rate_select) ? $past(tb_cnt[CCB_LCD_TAP_SLOW]) : $past(tb_cnt[CCB_LCD_TAP_FAST])))
		else $error("lcd frame tap wrong");
	a_tick_period: assert property (ce_i && tb_inc && tick_rate_select == 2'h0 && tb_cnt[6:0] == 7'h7F
		|=> tick_flag)
		else $error("tick flag missed the 128 period");
	a_tick_irq_gate: assert property (ce_i |=> tick_interrupt_o == ($past(tick_flag) && $past(tick_irq_enable)))
		else $error("tick interrupt not gated by enable");
	a_reset_clears_ctrl: assert property (ce_i && rst_ord |=>
		system_clock_select == CCB_SYS_SEL_RST && alternate_map_select_o == CCB_MAP_RST)
		else $error("ordinary reset left control bits set");
	a_rsvd_read_zero: assert property (ce_i && reg_rd_i && reg_addr_i == CCB_ADDR_CLK_CTRL |=>
		reg_rdata_o[5:4] == 2'b00)
		else $error("reserved bits read as one");
	a_main_preset: assert property (ce_i && !main_crystal_enable |=>
		main_div == CCB_DIV_PRESET && main_stab == CCB_STAB_PRESET && !main_clock_ready_flag)
		else $error("main divider not preset while disabled");
	a_main_ready_set: assert property (ce_i && stab_wrap && main_crystal_enable |=> main_clock_ready_flag)
		else $error("main ready flag missed the overflow");

endmodule : ccb_clock_ctrl

// ### verification/ccb_crystal_model.sv
// crystal sources seen by the clock control block: free-running sub, gated main
`timescale 1ns/1ps
module ccb_crystal_model
(
	// system clock and main crystal enable
	input wire logic clk_sys_i,
	input wire logic main_run_i,
	// crystal levels
	output logic sub_clk_o,
	output logic main_clk_o
);
	logic half = 1'b0;
	initial
	begin
		sub_clk_o = 1'b0;
		main_clk_o = 1'b0;
	end
	// each level holds two system cycles so the block sees every crystal edge
	always @(posedge clk_sys_i)
	begin
		half <= ~half;
		if (half)
		begin
			sub_clk_o <= ~sub_clk_o;
			// a stopped main crystal freezes at its last level
			if (main_run_i)
				main_clk_o <= ~main_clk_o;
		end
	end
endmodule : ccb_crystal_model

// ### verification/ccb_clock_ctrl_tb.sv
// self-checking bench for the clock and time base control block
`timescale 1ns/1ps
module ccb_clock_ctrl_tb
	import ccb_pkg::*;
;
	logic clk_sys_i, arst_n_i, ce_i, sub_clk, main_clk, ext_reset_i, watchdog_reset_i;
	logic stop_req_i, wait_req_i, ext_irq_i, spi_slave_event_i, irq_any_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic bus_clock_phase_o, cpu_run_o, periph_run_o, core_reset_o, main_crystal_run_o;
	logic alternate_map_select_o, lcd_frame_clock_o, tick_interrupt_o, watchdog_tap_o;
	logic rd_q = 1'b0;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h00000063;
	int compares = 0;
	int miscompares = 0;
	int n;
	int k;

	ccb_crystal_model XTAL (.clk_sys_i, .main_run_i(main_crystal_run_o), .sub_clk_o(sub_clk), .main_clk_o(main_clk));

	ccb_clock_ctrl DUT (.clk_sys_i, .arst_n_i, .ce_i, .sub_crystal_clock_i(sub_clk), .main_crystal_clock_i(main_clk),
		.ext_reset_i, .watchdog_reset_i, .stop_req_i, .wait_req_i, .ext_irq_i, .spi_slave_event_i, .irq_any_i,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_clock_phase_o, .cpu_run_o,
		.periph_run_o, .core_reset_o, .main_crystal_run_o, .alternate_map_select_o, .lcd_frame_clock_o,
		.tick_interrupt_o, .watchdog_tap_o);

	initial
	begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction : xs

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// the expected read data is queued here and compared by the output monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
	endtask : rd

	// cycles from one rising edge of a tap to the next; first call aligns
	task automatic rise(input int sel, output int m);
		logic p;
		logic v;
		p = 1'b1;
		for (m = 1; m < 20000; m++)
		begin
			@(negedge clk_sys_i);
			v = (sel == 0) ? watchdog_tap_o : ((sel == 1) ? lcd_frame_clock_o : bus_clock_phase_o);
			if (v === 1'b1 && !p)
				break;
			p = v;
		end
	endtask : rise

	task automatic sleep_wake(input logic stp, input int src);
		@(posedge clk_sys_i);
		stop_req_i <= stp;
		wait_req_i <= !stp;
		@(posedge clk_sys_i);
		stop_req_i <= 1'b0;
		wait_req_i <= 1'b0;
		@(negedge clk_sys_i);
		check(cpu_run_o, 1'b0);
		check(periph_run_o, !stp);
		@(posedge clk_sys_i);
		case (src)
			0: ext_irq_i <= 1'b1;
			1: spi_slave_event_i <= 1'b1;
			2: irq_any_i <= 1'b1;
			default: watchdog_reset_i <= 1'b1;
		endcase
		@(posedge clk_sys_i);
		{ext_irq_i, spi_slave_event_i, irq_any_i, watchdog_reset_i} <= 4'h0;
		@(negedge clk_sys_i);
		check(cpu_run_o, 1'b1);
		check(periph_run_o, 1'b1);
	endtask : sleep_wake

	always @(posedge clk_sys_i) rd_q <= reg_rd_i;
	always @(negedge clk_sys_i)
	begin
		if (rd_q)
			check(reg_rdata_o, exp_q.pop_front());
		else
			check(reg_rdata_o, 8'h00);
	end

	initial
	begin
		#(90000 * 25);
		miscompares++;
		test_done();
	end

	initial
	begin
		arst_n_i = 1'b0;
		ce_i = 1'b1;
		{ext_reset_i, watchdog_reset_i, stop_req_i, wait_req_i} = 4'h0;
		{ext_irq_i, spi_slave_event_i, irq_any_i, reg_wr_i, reg_rd_i} = 5'h00;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		repeat (5) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(negedge clk_sys_i);
		check(core_reset_o, 1'b1);
		// 16264 sub edges at one edge per four system cycles
		for (n = 1; n < 70000 && core_reset_o !== 1'b0; n++)
			@(negedge clk_sys_i);
		check(16'(n > 65040 && n < 65072), 16'h0001);
		rd(CCB_ADDR_CLK_CTRL, 8'h40);
		rd(8'h3F, 8'h00);
		for (k = 0; k < 4; k++)
		begin
			seed = xs(seed);
			wr(CCB_ADDR_CLK_CTRL, seed[7:0]);
			@(negedge clk_sys_i);
			check(alternate_map_select_o, seed[0]);
			// the crystal enable output follows the stored enable one cycle later
			@(negedge clk_sys_i);
			check(main_crystal_run_o, seed[1]);
			rd(CCB_ADDR_CLK_CTRL, 8'h40 | (seed[7:0] & 8'h0F));
		end
		wr(8'h3F, 8'hFF);
		@(posedge clk_sys_i);
		ext_reset_i <= 1'b1;
		@(posedge clk_sys_i);
		ext_reset_i <= 1'b0;
		@(negedge clk_sys_i);
		check(core_reset_o, 1'b1);
		repeat (2) @(negedge clk_sys_i);
		check(core_reset_o, 1'b0);
		rd(CCB_ADDR_CLK_CTRL, 8'h40);
		wr(CCB_ADDR_TB_CTRL2, 8'h00);
		rise(0, n);
		rise(0, n);
		check(16'(n), 16'h0200);
		check(tick_interrupt_o, 1'b0);
		rd(CCB_ADDR_TB_CTRL2, 8'h80);
		wr(CCB_ADDR_TB_CTRL2, 8'hC0);
		rd(CCB_ADDR_TB_CTRL2, 8'h40);
		@(posedge clk_sys_i);
		stop_req_i <= 1'b1;
		@(posedge clk_sys_i);
		stop_req_i <= 1'b0;
		irq_any_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		irq_any_i <= 1'b0;
		@(negedge clk_sys_i);
		check(cpu_run_o, 1'b0);
		for (n = 0; n < 600 && cpu_run_o !== 1'b1; n++)
			@(negedge clk_sys_i);
		check(tick_interrupt_o, 1'b1);
		check(periph_run_o, 1'b1);
		wr(CCB_ADDR_TB_CTRL2, 8'h80);
		wr(CCB_ADDR_TB_CTRL1, 8'h00);
		rise(1, n);
		rise(1, n);
		check(16'(n), 16'h0100);
		wr(CCB_ADDR_TB_CTRL1, 8'h01);
		rise(1, n);
		rise(1, n);
		check(16'(n), 16'h0200);
		// main source with the main crystal off: the time base, and so the lcd tap, must stand still
		wr(CCB_ADDR_TB_CTRL1, 8'h02);
		repeat (2) @(negedge clk_sys_i);
		n = 0;
		repeat (300)
		begin
			k = lcd_frame_clock_o;
			@(negedge clk_sys_i);
			n += int'(lcd_frame_clock_o !== k[0]);
		end
		check(16'(n), 16'h0000);
		// bus clock period per select in system cycles; crystal rising edges come every four
		for (k = 0; k < 4; k++)
		begin
			wr(CCB_ADDR_CLK_CTRL, 8'(k * 4 + 2));
			rise(2, n);
			rise(2, n);
			rise(2, n);
			check(16'(n), (k == 2) ? 16'h0100 : ((k == 1) ? 16'h0010 : 16'h0008));
		end
		sleep_wake(1'b1, 0);
		sleep_wake(1'b1, 1);
		sleep_wake(1'b0, 2);
		sleep_wake(1'b0, 0);
		wr(CCB_ADDR_CLK_CTRL, 8'h0D);
		sleep_wake(1'b1, 3);
		check(core_reset_o, 1'b1);
		repeat (2) @(negedge clk_sys_i);
		check(core_reset_o, 1'b0);
		rd(CCB_ADDR_CLK_CTRL, 8'h40);
		// a stop request while the clock enable is low must not be taken
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		stop_req_i <= 1'b1;
		@(posedge clk_sys_i);
		ce_i <= 1'b1;
		stop_req_i <= 1'b0;
		@(negedge clk_sys_i);
		check(cpu_run_o, 1'b1);
		repeat (3) @(posedge clk_sys_i);
		test_done();
	end
endmodule : ccb_clock_ctrl_tb
